/* File: logic/supervisor_pkg.sv */
// Constants and carrier types for the supervisor with watchdog and chip-enable
// gating. Assumes a single 250 MHz clock and synchronous supply comparator
// levels.
package supervisor_pkg;

   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned RESET_TIMEOUT_MS = 200;
   localparam int unsigned WATCHDOG_TIMEOUT_MS = 1600;
   localparam int unsigned CE_HOLD_NS = 15000;
   localparam int unsigned KICK_MIN_NS = 50;
   localparam longint unsigned RESET_TIMEOUT_CYC =
      longint'(RESET_TIMEOUT_MS) * 1000 * CLK_MHZ;
   localparam longint unsigned WATCHDOG_TIMEOUT_CYC =
      longint'(WATCHDOG_TIMEOUT_MS) * 1000 * CLK_MHZ;
   localparam longint unsigned CE_HOLD_CYC =
      (longint'(CE_HOLD_NS) * CLK_MHZ) / 1000;
   localparam longint unsigned KICK_MIN_CYC =
      (longint'(KICK_MIN_NS) * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W = 32;

   typedef enum {
      ST_POWER_LOW,
      ST_TIMEOUT,
      ST_RUN
   } rst_state_t;

   typedef enum {
      CE_PASS,
      CE_HOLD,
      CE_OFF
   } ce_state_t;

   typedef struct packed {
      logic reset_out_n;
      logic battery_connect;
      logic seal_enabled;
   } supervisor_status_t;

   typedef struct packed {
      logic ce_out_n;
      logic ce_in_high_z;
   } ce_gate_t;

endpackage : supervisor_pkg

/* File: logic/supervisor.sv */
// Supervisor: reset timer, manual reset, watchdog, freshness seal and
// chip-enable gate. All inputs are taken as synchronous to MCLK.
// Assumes the supply comparators, the power switch and the pin drivers sit
// outside and reach this logic only as the levels on the ports below.
`timescale 1ns/100ps
module supervisor #(
   // Reset timeout in clock cycles.
   parameter int unsigned RESET_CYC = 32'(supervisor_pkg::RESET_TIMEOUT_CYC),
   // Watchdog timeout in clock cycles.
   parameter int unsigned WDOG_CYC =
      32'(supervisor_pkg::WATCHDOG_TIMEOUT_CYC),
   // Longest chip-enable hold after reset asserts, in clock cycles.
   parameter int unsigned CE_CYC = 32'(supervisor_pkg::CE_HOLD_CYC)
) (
   // Clock, reset, enable
   input wire logic MCLK,
   input wire logic RST_N,
   input wire logic CE,
   // Supply comparator levels
   input wire logic SUPPLY_ABOVE_THRESHOLD,
   input wire logic SUPPLY_BELOW_BATTERY,
   // Manual reset and seal arming level
   input wire logic MANUAL_RESET_N,
   input wire logic POWER_FAIL_OUT_N_IN,
   // Watchdog kick pin, four signals
   input wire logic WATCHDOG_KICK_IN,
   input wire logic WATCHDOG_KICK_FLOATING,
   output logic WATCHDOG_KICK_OUT,
   output logic WATCHDOG_KICK_OE,
   // Chip-enable gate
   input wire logic CHIP_ENABLE_IN_N,
   output logic CHIP_ENABLE_OUT_N,
   output logic CHIP_ENABLE_IN_HIGH_Z,
   // Status
   output logic RESET_OUT_N,
   output logic BATTERY_CONNECT,
   output logic SEAL_ENABLED
);

   supervisor_pkg::rst_state_t state, next_state;
   logic [31:0] rst_cnt, next_rst_cnt;
   logic seal, next_seal;
   logic arm_seen, next_arm_seen;
   logic mr_held, next_mr_held;
   logic kick_edge;
   logic [31:0] wd_cnt, next_wd_cnt;
   logic kick_prev, next_kick_prev;
   logic wd_fire;
   logic backup_mode;
   logic mr_effective;
   logic kick_level;
   logic int_drive;
   supervisor_pkg::ce_state_t ce_state, next_ce_state;
   logic [31:0] ce_cnt, next_ce_cnt;
   supervisor_pkg::supervisor_status_t status;
   supervisor_pkg::ce_gate_t gate;

   // Backup needs both conditions: supply below threshold and below battery.
   assign backup_mode = !SUPPLY_ABOVE_THRESHOLD && SUPPLY_BELOW_BATTERY;
   // manual reset masking.
   // The latched seal is cleared as the supply returns, so inside a timeout
   // the armed flag is what marks a sealing cycle.
   assign mr_effective = !MANUAL_RESET_N &&
      !((seal || arm_seen) && state == supervisor_pkg::ST_TIMEOUT);

   // internal keeper on floating input.
   // The keeper pulses high after 7/8 of the timeout; the edge clears the
   // counter well before it could fire.
   assign int_drive = (wd_cnt >= (WDOG_CYC - (WDOG_CYC >> 3)));
   assign kick_level = WATCHDOG_KICK_FLOATING ? int_drive : WATCHDOG_KICK_IN;
   assign WATCHDOG_KICK_OUT = int_drive;
   assign WATCHDOG_KICK_OE = WATCHDOG_KICK_FLOATING;
   assign wd_fire = (state == supervisor_pkg::ST_RUN) &&
      (wd_cnt >= WDOG_CYC - 1);
   // edge detect on the resolved kick level.
   assign kick_edge = kick_level != kick_prev;

   // Reset sequencer. Power-low keeps the timer cleared, timeout counts the
   // hold and run releases reset. Seal arming is watched in the timeout and
   // latched on the next supply drop from run.
   always_comb begin
      next_state = state;
      next_rst_cnt = rst_cnt;
      next_seal = seal;
      next_arm_seen = arm_seen;
      next_mr_held = 1'b0;
      case (state)
         supervisor_pkg::ST_POWER_LOW: begin
            next_rst_cnt = '0;
            if (SUPPLY_ABOVE_THRESHOLD) begin
               next_state = supervisor_pkg::ST_TIMEOUT;
               next_seal = 1'b0;
               next_arm_seen = 1'b0;
            end
         end
         supervisor_pkg::ST_TIMEOUT: begin
            if (!POWER_FAIL_OUT_N_IN && MANUAL_RESET_N) begin
               next_arm_seen = 1'b1;
            end
            if (!SUPPLY_ABOVE_THRESHOLD) begin
               next_state = supervisor_pkg::ST_POWER_LOW;
            end else if (mr_effective) begin
               next_rst_cnt = '0;
               next_mr_held = 1'b1;
            end else if (rst_cnt >= RESET_CYC - 1) begin
               next_state = supervisor_pkg::ST_RUN;
               next_rst_cnt = '0;
            end else if (mr_held) begin
               // The first edge after release restarts the count as a fresh
               // entry does, so the full timeout follows the release.
               next_rst_cnt = '0;
            end else begin
               next_rst_cnt = rst_cnt + 32'h0000_0001;
            end
         end
         supervisor_pkg::ST_RUN: begin
            if (!SUPPLY_ABOVE_THRESHOLD) begin
               next_state = supervisor_pkg::ST_POWER_LOW;
               // seal latches on supply drop if armed.
               next_seal = arm_seen;
            end else if (mr_effective || wd_fire) begin
               next_state = supervisor_pkg::ST_TIMEOUT;
            end
         end
         default: begin
            next_state = supervisor_pkg::ST_POWER_LOW;
            next_rst_cnt = '0;
         end
      endcase
   end

   // Sequencer registers; CE low freezes every group of state.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         state <= supervisor_pkg::ST_POWER_LOW;
         rst_cnt <= '0;
         seal <= 1'b0;
         arm_seen <= 1'b0;
         mr_held <= 1'b0;
      end else if (CE) begin
         state <= next_state;
         rst_cnt <= next_rst_cnt;
         seal <= next_seal;
         arm_seen <= next_arm_seen;
         mr_held <= next_mr_held;
      end
   end

   // Watchdog counter. A level change between two edges counts as a kick,
   // so a pulse must span one clock edge to be seen; at this clock a pulse
   // of the minimum width always does.
   always_comb begin
      next_kick_prev = kick_level;
      next_wd_cnt = wd_cnt + 32'h0000_0001;
      if (state != supervisor_pkg::ST_RUN || backup_mode) begin
         next_wd_cnt = '0;
      end else if (kick_edge || wd_fire) begin
         next_wd_cnt = '0;
      end else begin
         next_wd_cnt = wd_cnt + 32'h0000_0001;
      end
   end

   // Watchdog registers.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         wd_cnt <= '0;
         kick_prev <= 1'b0;
      end else if (CE) begin
         wd_cnt <= next_wd_cnt;
         kick_prev <= next_kick_prev;
      end
   end

   // Chip-enable gate. A write in flight when reset asserts may finish in
   // the hold state; the gate then stays off until the sequencer runs, so
   // no stray write can reach the RAM during the timeout.
   always_comb begin
      next_ce_state = ce_state;
      next_ce_cnt = '0;
      case (ce_state)
         supervisor_pkg::CE_PASS: begin
            if (next_state != supervisor_pkg::ST_RUN) begin
               if (CHIP_ENABLE_IN_N) begin
                  next_ce_state = supervisor_pkg::CE_OFF;
               end else begin
                  next_ce_state = supervisor_pkg::CE_HOLD;
               end
            end
         end
         supervisor_pkg::CE_HOLD: begin
            next_ce_cnt = ce_cnt + 32'h0000_0001;
            // up to the hold time or input high.
            if (CHIP_ENABLE_IN_N || ce_cnt >= CE_CYC - 1) begin
               next_ce_state = supervisor_pkg::CE_OFF;
            end
         end
         supervisor_pkg::CE_OFF: begin
            // enabled only after the reset timeout.
            if (next_state == supervisor_pkg::ST_RUN) begin
               next_ce_state = supervisor_pkg::CE_PASS;
            end
         end
         default: next_ce_state = supervisor_pkg::CE_OFF;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         ce_state <= supervisor_pkg::CE_OFF;
         ce_cnt <= '0;
      end else if (CE) begin
         ce_state <= next_ce_state;
         ce_cnt <= next_ce_cnt;
      end
   end

   // Status outputs follow the next state, so the registered pins change on
   // the same edge as the state they report.
   always_comb begin
      status = '0;
      if (next_state == supervisor_pkg::ST_RUN) begin
         status.reset_out_n = 1'b1;
      end else begin
         status.reset_out_n = 1'b0;
      end
      if (next_seal) begin
         status.battery_connect = 1'b0;
         status.seal_enabled = 1'b1;
      end else begin
         status.battery_connect = 1'b1;
         status.seal_enabled = 1'b0;
      end
   end

   // Gate outputs, decoded from the next gate state.
   always_comb begin
      gate = '0;
      case (next_ce_state)
         supervisor_pkg::CE_PASS: begin
            gate.ce_out_n = CHIP_ENABLE_IN_N;
            gate.ce_in_high_z = 1'b0;
         end
         supervisor_pkg::CE_HOLD: begin
            gate.ce_out_n = 1'b0;
            gate.ce_in_high_z = 1'b0;
         end
         supervisor_pkg::CE_OFF: begin
            gate.ce_out_n = 1'b1;
            gate.ce_in_high_z = 1'b1;
         end
         default: begin
            gate.ce_out_n = 1'b1;
            gate.ce_in_high_z = 1'b1;
         end
      endcase
   end

   // Reset and seal output registers.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         RESET_OUT_N <= 1'b0;
         BATTERY_CONNECT <= 1'b1;
         SEAL_ENABLED <= 1'b0;
      end else if (CE) begin
         RESET_OUT_N <= status.reset_out_n;
         BATTERY_CONNECT <= status.battery_connect;
         SEAL_ENABLED <= status.seal_enabled;
      end
   end

   // Chip-enable output registers. The pass path is registered as well, so
   // the gate adds one clock of delay that write timing must allow for.
   always_ff @(posedge MCLK) begin
      if (!RST_N) begin
         CHIP_ENABLE_OUT_N <= 1'b1;
         CHIP_ENABLE_IN_HIGH_Z <= 1'b1;
      end else if (CE) begin
         CHIP_ENABLE_OUT_N <= gate.ce_out_n;
         CHIP_ENABLE_IN_HIGH_Z <= gate.ce_in_high_z;
      end
   end

endmodule : supervisor

/* File: verification/supervisor_monitor.sv */
// Port-level checks of the supervisor: reset timing, watchdog, CE gate, seal.
// Assumes CE is held high, so every clock edge is a working edge.
`timescale 1ns/100ps
module supervisor_monitor #(
   parameter int unsigned WDOG_CYC = 64
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // Causes
   input wire logic SUPPLY_ABOVE_THRESHOLD,
   input wire logic MANUAL_RESET_N,
   input wire logic WATCHDOG_KICK_IN,
   input wire logic WATCHDOG_KICK_FLOATING,
   input wire logic CHIP_ENABLE_IN_N,
   // Effects
   input wire logic WATCHDOG_KICK_OE,
   input wire logic CHIP_ENABLE_OUT_N,
   input wire logic CHIP_ENABLE_IN_HIGH_Z,
   input wire logic RESET_OUT_N,
   input wire logic BATTERY_CONNECT,
   input wire logic SEAL_ENABLED
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   logic kick_last;
   int unsigned quiet;
   // Cycles of released reset with no kick edge; slack of two for the
   // edge detector and the registered output.
   always_ff @(posedge MCLK) begin
      kick_last <= WATCHDOG_KICK_IN;
      if (!RST_N || !RESET_OUT_N || kick_last != WATCHDOG_KICK_IN) begin
         quiet <= 0;
      end else begin
         quiet <= quiet + 1;
      end
   end
   a_supply_low_reset: assert property (
      !SUPPLY_ABOVE_THRESHOLD |=> !RESET_OUT_N) else $error("reset not low");
   a_timeout_after_rise: assert property (
      $rose(SUPPLY_ABOVE_THRESHOLD) |=> !RESET_OUT_N [*8])
      else $error("reset released early");
   a_reset_min_width: assert property (
      $fell(RESET_OUT_N) |-> !RESET_OUT_N [*8]) else $error("short reset");
   a_manual_reset: assert property (
      !MANUAL_RESET_N && RESET_OUT_N |=> !RESET_OUT_N)
      else $error("manual reset missed");
   a_ce_high_follows: assert property (
      CHIP_ENABLE_IN_N |=> CHIP_ENABLE_OUT_N) else $error("ce out stuck low");
   a_ce_pull_up: assert property (
      CHIP_ENABLE_IN_HIGH_Z |-> CHIP_ENABLE_OUT_N) else $error("no pull-up");
   a_ce_hold_bound: assert property (
      $fell(RESET_OUT_N) |-> ##[0:8] CHIP_ENABLE_OUT_N)
      else $error("ce hold too long");
   a_gate_stays_off: assert property (
      !RESET_OUT_N && CHIP_ENABLE_IN_HIGH_Z |=>
      CHIP_ENABLE_IN_HIGH_Z || RESET_OUT_N) else $error("gate reopened");
   a_seal_no_battery: assert property (
      SEAL_ENABLED |-> !BATTERY_CONNECT) else $error("battery on while sealed");
   a_keeper_enable: assert property (
      WATCHDOG_KICK_OE == WATCHDOG_KICK_FLOATING) else $error("keeper enable");
   a_wdog_bound: assert property (
      quiet <= WDOG_CYC + 2) else $error("watchdog did not expire");
endmodule : supervisor_monitor
bind supervisor supervisor_monitor #(.WDOG_CYC(WDOG_CYC)) mon (
   .MCLK(MCLK), .RST_N(RST_N), .MANUAL_RESET_N(MANUAL_RESET_N),
   .SUPPLY_ABOVE_THRESHOLD(SUPPLY_ABOVE_THRESHOLD),
   .WATCHDOG_KICK_IN(WATCHDOG_KICK_IN), .WATCHDOG_KICK_OE(WATCHDOG_KICK_OE),
   .WATCHDOG_KICK_FLOATING(WATCHDOG_KICK_FLOATING),
   .CHIP_ENABLE_IN_N(CHIP_ENABLE_IN_N), .CHIP_ENABLE_OUT_N(CHIP_ENABLE_OUT_N),
   .CHIP_ENABLE_IN_HIGH_Z(CHIP_ENABLE_IN_HIGH_Z), .RESET_OUT_N(RESET_OUT_N),
   .BATTERY_CONNECT(BATTERY_CONNECT), .SEAL_ENABLED(SEAL_ENABLED));

/* File: verification/cpu_ram_model.sv */
// Processor side: toggles the watchdog pin while enabled and running.
// Assumes the bench resolves the pin against the internal keeper.
`timescale 1ns/100ps
module cpu_ram_model #(
   parameter int PERIOD = 20
) (
   // Clock and status
   input wire logic mclk,
   input wire logic reset_out_n,
   input wire logic kick_en,
   // Watchdog pin drive
   output logic kick
);
   int cnt = 0;
   initial kick = 1'b0;
   always @(negedge mclk) begin
      cnt <= (cnt + 1) % PERIOD;
      if (kick_en && reset_out_n && cnt == 0) begin
         kick <= ~kick;
      end
   end
endmodule : cpu_ram_model

/* File: verification/test_supervisor.sv */
// Self-checking bench for the supervisor with shortened timeouts.
// Inputs change on the falling edge; CE is held high throughout.
`timescale 1ns/100ps
module test_supervisor;
   localparam int RC = 20;
   localparam int WC = 64;
   localparam int CC = 5;
   logic mclk = 0, rst_n = 0, sup = 0, below = 0, mr_n = 1, pfo_n = 1;
   logic flt = 0, kick_en = 0, ce_in_n = 1;
   logic kick_m, kick_out, kick_oe, ce_out_n, hiz, rst_out_n, backup_battery_in, seal;
   wire kick = kick_oe ? kick_out : kick_m;
   int fail_count = 0, checks = 0, n;
   initial forever #2 mclk = ~mclk;
   supervisor #(.RESET_CYC(RC), .WDOG_CYC(WC), .CE_CYC(CC)) dut (
      .MCLK(mclk), .RST_N(rst_n), .CE(1'b1), .SUPPLY_ABOVE_THRESHOLD(sup),
      .SUPPLY_BELOW_BATTERY(below), .MANUAL_RESET_N(mr_n),
      .POWER_FAIL_OUT_N_IN(pfo_n), .WATCHDOG_KICK_IN(kick),
      .WATCHDOG_KICK_FLOATING(flt), .WATCHDOG_KICK_OUT(kick_out),
      .WATCHDOG_KICK_OE(kick_oe), .CHIP_ENABLE_IN_N(ce_in_n),
      .CHIP_ENABLE_OUT_N(ce_out_n), .CHIP_ENABLE_IN_HIGH_Z(hiz),
      .RESET_OUT_N(rst_out_n), .BATTERY_CONNECT(backup_battery_in), .SEAL_ENABLED(seal));
   cpu_ram_model #(.PERIOD(20)) partner (.mclk(mclk),
      .reset_out_n(rst_out_n), .kick_en(kick_en), .kick(kick_m));
   task report_and_stop;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   // Counts falling edges until reset releases; a hang ends the run.
   task wait_hi(output int k);
      k = 0;
      while (rst_out_n !== 1'b1 && k < 1000) begin
         @(negedge mclk);
         k++;
      end
      if (k >= 1000) begin
         fail_count++;
         $display("BAD %0t reset never released", $time);
         report_and_stop();
      end
   endtask : wait_hi
   task t_manual;
      mr_n = 0;
      repeat (6) @(negedge mclk);
      chk(rst_out_n, 0);
      mr_n = 1;
      wait_hi(n);
      chk(n, RC + 1);
      $display("manual reset done");
   endtask : t_manual
   task t_watchdog;
      kick_en = 1;
      repeat (300) @(negedge mclk);
      chk(rst_out_n, 1);
      kick_en = 0;
      n = 0;
      while (rst_out_n === 1'b1 && n < 200) begin
         @(negedge mclk);
         n++;
      end
      chk(n > WC - 22 && n <= WC + 2, 1);
      wait_hi(n);
      chk(n, RC);
      flt = 1;
      repeat (4 * WC) @(negedge mclk);
      chk(rst_out_n & kick_oe, 1);
      // The pin stays floating, so the keeper services the watchdog later on.
      $display("watchdog done");
   endtask : t_watchdog
   task t_ce;
      ce_in_n = 0;
      @(negedge mclk);
      chk(ce_out_n, 0);
      ce_in_n = 1;
      @(negedge mclk);
      chk(ce_out_n, 1);
      ce_in_n = 0;
      @(negedge mclk);
      mr_n = 0;
      n = 0;
      while (ce_out_n === 1'b0 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      chk(n >= CC && n <= CC + 2, 1);
      mr_n = 1;
      repeat (RC / 2) @(negedge mclk);
      chk(ce_out_n & hiz, 1);
      wait_hi(n);
      @(negedge mclk);
      chk(ce_out_n, 0);
      ce_in_n = 1;
      $display("chip-enable gate done");
   endtask : t_ce
   task t_seal;
      pfo_n = 0;
      sup = 0;
      below = 1;
      @(negedge mclk);
      @(negedge mclk);
      chk(rst_out_n, 0);
      chk(ce_out_n & hiz, 1);
      sup = 1;
      repeat (3) @(negedge mclk);
      mr_n = 0;
      repeat (3) @(negedge mclk);
      mr_n = 1;
      wait_hi(n);
      chk(n, RC - 5);
      sup = 0;
      repeat (3) @(negedge mclk);
      chk({seal, backup_battery_in, rst_out_n}, 3'b100);
      pfo_n = 1;
      below = 0;
      sup = 1;
      repeat (2) @(negedge mclk);
      chk(seal, 0);
      wait_hi(n);
      $display("seal done");
   endtask : t_seal
   initial begin
      repeat (8) @(negedge mclk);
      rst_n = 1;
      sup = 1;
      wait_hi(n);
      chk(n, RC + 1);
      chk(backup_battery_in, 1);
      $display("power-up done");
      t_manual;
      t_watchdog;
      t_ce;
      t_seal;
      report_and_stop();
   end
endmodule : test_supervisor
